// *** logic/supervisor_cfg.svh ***
// Constants for the processor supervisor and watchdog.
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH

// ----------------------------------------
// Clock and timebase
// ----------------------------------------
`define CLK_PERIOD_NS 4
`define TICK_PERIOD_NS 1000000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define NS_PER_MS 1000000

// ----------------------------------------
// Interval figures and their tick counts
// ----------------------------------------
`define MS_W 11
`define TIMEOUT_SHORT_MS 150
`define TIMEOUT_MID_MS 600
`define TIMEOUT_LONG_MS 1200
`define ACTIVE_MS 610
`define PB_IGNORE_MS 1
`define PB_GUARANTEE_MS 20
`define PB_QUALIFY_MS 4
`define FAIL_DELAY_NS 50000
`define MS_TO_TICKS(ms) (`MS_W'((ms) * `NS_PER_MS / `TICK_PERIOD_NS))
`define FAIL_DELAY_CYCLES (`FAIL_DELAY_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset values
// ----------------------------------------
`define COUNT_RESET 11'h000
`define STROBE_RESET 1'h0

`endif

// *** logic/supervisor_pkg.sv ***
// Types shared by the supervisor modules.
package supervisor_pkg;
`include "supervisor_cfg.svh"

  typedef enum logic [1:0]
  {
    TSEL_SHORT = 2'b00,
    TSEL_MID = 2'b01,
    TSEL_LONG = 2'b10
  } tsel_type;

  typedef enum logic
  {
    MODE_RUN = 1'b0,
    MODE_HOLD = 1'b1
  } mode_type;

  typedef struct packed
  {
    logic below_4v50;
    logic below_4v75;
  } supply_type;

  typedef struct packed
  {
    mode_type mode;
    logic strobe_prev;
    logic [`MS_W-1:0] db_count;
    logic [`MS_W-1:0] wd_count;
    logic [`MS_W-1:0] act_count;
    logic reset_out;
    logic reset_n_oe;
    logic reset_n_drive;
  } state_type;

  // Code 2'b11 cannot come from a three-level pin; it falls to the longest.
  function automatic logic [`MS_W-1:0] timeout_ticks(input logic [1:0] sel);
    logic [`MS_W-1:0] t;
    t = `MS_TO_TICKS(`TIMEOUT_LONG_MS);
    case (sel)
      TSEL_SHORT: t = `MS_TO_TICKS(`TIMEOUT_SHORT_MS);
      TSEL_MID: t = `MS_TO_TICKS(`TIMEOUT_MID_MS);
      default: t = `MS_TO_TICKS(`TIMEOUT_LONG_MS);
    endcase
    return t;
  endfunction

endpackage

// *** logic/timebase_tick.sv ***
// Free-running prescaler that emits a one-cycle millisecond tick.
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module timebase_tick
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Tick enable
  output logic tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);

  typedef struct packed
  {
    logic pulse;
    logic [CW-1:0] count;
  } prescale_type;

  prescale_type st;
  prescale_type next_st;

  always_comb
  begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (st.count == CW'(TICK_CYCLES - 1))
    begin
      next_st.count = '0;
      next_st.pulse = 1'b1;
    end
    else
    begin
      next_st.count = st.count + CW'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.pulse;

endmodule

// *** logic/cpu_supervisor_watchdog.sv ***
// Processor supervisor: supply fail, push-button and strobe watchdog.
`timescale 1ns/1ps
`include "supervisor_cfg.svh"
module cpu_supervisor_watchdog
  import supervisor_pkg::*;
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Supply monitor
  input wire supply_type supply,
  input wire logic trip_select,
  // Processor and operator inputs
  input wire logic strobe,
  input wire logic pushbutton_reset_n,
  input wire logic [1:0] timeout_select,
  // Reset outputs
  output logic reset_out,
  output logic reset_n_drive,
  output logic reset_n_oe
);

  // ----------------------------------------
  // Timebase
  // ----------------------------------------
  logic tick;

  // One prescaler serves every interval; the per-interval counters
  // restart on their own events so the shared tick costs at most one
  // tick of accuracy.
  timebase_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick)
  );

  // ----------------------------------------
  // Event decode
  // ----------------------------------------
  state_type st;
  state_type next_st;
  logic supply_fail;
  logic strobe_fall;
  logic pb_hit;
  logic wd_expired;
  logic [`MS_W-1:0] timeout_limit;

  always_comb
  begin
    // Sense 1 selects the 4.5 V trip, sense 0 the 4.75 V trip.
    supply_fail = trip_select ? supply.below_4v50
                              : supply.below_4v75;
    strobe_fall = st.strobe_prev && !strobe;
    timeout_limit = timeout_ticks(timeout_select);
    wd_expired = (st.mode == MODE_RUN)
                 && (st.wd_count >= timeout_limit);
    pb_hit = !pushbutton_reset_n
             && (st.db_count == `MS_TO_TICKS(`PB_QUALIFY_MS));
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.strobe_prev = strobe;

    // Any high level restarts qualification, so short lows are lost.
    if (pushbutton_reset_n)
      next_st.db_count = `COUNT_RESET;
    else if (tick && !pb_hit)
      next_st.db_count = st.db_count + `MS_W'(1);

    case (st.mode)
      MODE_RUN:
      begin
        if (strobe_fall)
          next_st.wd_count = `COUNT_RESET;
        else if (tick)
          next_st.wd_count = st.wd_count + `MS_W'(1);
        if (supply_fail || pb_hit || wd_expired)
        begin
          next_st.mode = MODE_HOLD;
          next_st.act_count = `COUNT_RESET;
        end
      end
      MODE_HOLD:
      begin
        // The watchdog sleeps while the processor is held in reset.
        next_st.wd_count = `COUNT_RESET;
        if (supply_fail || pb_hit)
          next_st.act_count = `COUNT_RESET;
        else if (st.act_count == `MS_TO_TICKS(`ACTIVE_MS))
          next_st.mode = MODE_RUN;
        else if (tick)
          next_st.act_count = st.act_count + `MS_W'(1);
      end
      default:
      begin
        next_st.mode = MODE_HOLD;
      end
    endcase

    // Outputs follow the registered mode so they can never disagree.
    next_st.reset_out = (next_st.mode == MODE_HOLD);
    next_st.reset_n_oe = (next_st.mode == MODE_HOLD);
    next_st.reset_n_drive = 1'b0;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Power-up enters the hold state so the processor sees a full
  // active-time reset before it runs.
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st.mode <= MODE_HOLD;
      st.strobe_prev <= `STROBE_RESET;
      st.db_count <= `COUNT_RESET;
      st.wd_count <= `COUNT_RESET;
      st.act_count <= `COUNT_RESET;
      st.reset_out <= 1'b1;
      st.reset_n_oe <= 1'b1;
      st.reset_n_drive <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign reset_out = st.reset_out;
  assign reset_n_oe = st.reset_n_oe;
  assign reset_n_drive = st.reset_n_drive;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_watchdog_expiry: assert property (
    st.mode == MODE_RUN && st.wd_count >= timeout_ticks(timeout_select)
    |=> reset_out)
    else $error("Watchdog expired without reset.");

  a_strobe_fall_restart: assert property (
    st.mode == MODE_RUN && st.strobe_prev && !strobe
    && !supply_fail && !pb_hit && !wd_expired
    |=> st.wd_count == `COUNT_RESET && !reset_out)
    else $error("Strobe fall did not restart the timeout.");

  a_strobe_rise_ignored: assert property (
    st.mode == MODE_RUN && !st.strobe_prev && strobe
    && st.wd_count != `COUNT_RESET
    && !supply_fail && !pb_hit && !wd_expired
    |=> st.wd_count >= $past(st.wd_count))
    else $error("Strobe rise was taken as activity.");

  a_watchdog_paced: assert property (
    st.wd_count != `COUNT_RESET && $changed(st.wd_count)
    |-> $past(tick))
    else $error("Watchdog counter advanced without a tick.");

  a_pushbutton_reset: assert property (
    !pushbutton_reset_n
    && st.db_count == `MS_TO_TICKS(`PB_QUALIFY_MS)
    |=> reset_out)
    else $error("Qualified push-button low gave no reset.");

  a_pushbutton_glitch: assert property (
    pushbutton_reset_n |=> st.db_count == `COUNT_RESET)
    else $error("Push-button high did not restart debounce.");

  a_fail_fast: assert property (
    supply_fail |=> reset_out && reset_n_oe && !reset_n_drive)
    else $error("Supply fail not reflected on reset outputs.");

  a_trip_select: assert property (
    !trip_select && supply.below_4v75 && !supply.below_4v50
    |=> reset_out)
    else $error("4.75 V trip ignored.");

  a_no_glitch: assert property (
    supply_fail ##1 supply_fail |-> reset_out ##1 reset_out)
    else $error("Reset released while supply failed.");

  a_active_release: assert property (
    $fell(reset_out)
    |-> st.act_count == `MS_TO_TICKS(`ACTIVE_MS) && !$past(supply_fail))
    else $error("Reset released before the active time.");

  a_active_bound: assert property (
    st.mode == MODE_HOLD |-> st.act_count <= `MS_TO_TICKS(`ACTIVE_MS))
    else $error("Active counter ran past the active time.");

  a_outputs_complement: assert property (
    reset_out == reset_n_oe && !reset_n_drive)
    else $error("Reset outputs disagree.");

  a_tick_paced: assert property (
    st.act_count != `COUNT_RESET && $changed(st.act_count)
    |-> $past(tick))
    else $error("Active counter advanced without a tick.");

  c_watchdog_reset: cover property (
    st.mode == MODE_RUN && wd_expired ##1 reset_out);
  c_pushbutton_reset: cover property (
    st.mode == MODE_RUN && pb_hit ##1 reset_out);
  c_fail_recover: cover property (
    st.mode == MODE_HOLD && $fell(supply_fail));
  c_active_release: cover property (
    $fell(reset_out));

endmodule

// *** dv/host_model.sv ***
// Host processor model that pulses the activity strobe.
`timescale 1ns/1ps
module host_model
(
  // Clock
  input wire logic core_clk,
  // Control from the bench
  input wire logic run,
  input wire logic kick,
  // Activity strobe
  output logic strobe
);
  logic [4:0] cnt = 5'h00;

  initial strobe = 1'h1;

  // Falls every 64 cycles stay far inside the shortest timeout.
  // A stopped host parks the strobe low, so that kick gives a rise.
  always @(posedge core_clk)
  begin
    cnt <= cnt + 5'h01;
    if (cnt == 5'h1F && (run || (strobe && !kick)))
      strobe <= ~strobe;
    else if (!run && kick)
      strobe <= 1'h1;
  end
endmodule

// *** dv/tb_cpu_supervisor_watchdog.sv ***
// Self-checking bench for the processor supervisor.
`timescale 1ns/1ps
module tb_cpu_supervisor_watchdog
  import supervisor_pkg::*;
;
  // Short tick keeps the millisecond counts quick to run.
  localparam int TC = 10;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  supply_type supply = supply_type'(2'h0);
  logic trip_select = 1'h0;
  logic strobe;
  logic pushbutton_reset_n = 1'h1;
  logic [1:0] timeout_select = 2'h0;
  logic reset_out;
  logic reset_n_drive;
  logic reset_n_oe;
  logic run = 1'h0;
  logic kick = 1'h0;
  wire reset_n_wire = reset_n_oe ? reset_n_drive : 1'h1;
  int error_cnt = 0;
  int total_checks = 0;
  int cycles = 0;
  int tmo[3] = '{150, 600, 1200};

  cpu_supervisor_watchdog #(.TICK_CYCLES(TC)) cpu_supervisor_watchdog_i
  (
    .core_clk(core_clk),
    .reset(reset),
    .supply(supply),
    .trip_select(trip_select),
    .strobe(strobe),
    .pushbutton_reset_n(pushbutton_reset_n),
    .timeout_select(timeout_select),
    .reset_out(reset_out),
    .reset_n_drive(reset_n_drive),
    .reset_n_oe(reset_n_oe)
  );

  host_model host_model_i
  (
    .core_clk(core_clk),
    .run(run),
    .kick(kick),
    .strobe(strobe)
  );

  always #2 core_clk = ~core_clk;

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step();
    @(posedge core_clk);
    #1;
  endtask

  // reset_out must hold lvl for n cycles; the reset_n wire is checked for ~lvl once, at the end.
  task automatic watch(input int n, input logic lvl);
    #1;
    for (int i = 0; i < n && reset_out === lvl; i++)
      step();
    check("reset_out held", lvl, reset_out);
    check("reset_n wire", ~lvl, reset_n_wire);
  endtask

  // Outputs must reach lvl within max cycles.
  task automatic reach(input logic lvl, input int max);
    #1;
    for (int i = 0; i < max && reset_out !== lvl; i++)
      step();
    check("reset_out reached", lvl, reset_out);
    check("reset_n wire", ~lvl, reset_n_wire);
  endtask

  task automatic recover();
    watch(610 * TC - 10, 1'h1);
    reach(1'h0, 40);
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 95000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    reset <= 1'h0;
    run <= 1'h1;
    recover();
    $display("test power_up done");
    for (int t = 0; t < 2; t++)
    begin
      @(posedge core_clk)
      begin
        trip_select <= t[0];
        supply <= supply_type'(t[0] ? 2'h1 : 2'h2);
      end
      watch(300, 1'h0);
      @(posedge core_clk) supply <= supply_type'(t[0] ? 2'h3 : 2'h1);
      step();
      check("fail response", 1'h1, reset_out);
      watch(t[0] ? 200 : 7000, 1'h1);
      @(posedge core_clk) supply <= supply_type'(2'h0);
      recover();
    end
    $display("test supply done");
    repeat (3)
    begin
      @(posedge core_clk) pushbutton_reset_n <= 1'h0;
      repeat (TC - 2) @(posedge core_clk);
      pushbutton_reset_n <= 1'h1;
      repeat (TC) @(posedge core_clk);
    end
    watch(300, 1'h0);
    @(posedge core_clk) pushbutton_reset_n <= 1'h0;
    reach(1'h1, 20 * TC);
    @(posedge core_clk) pushbutton_reset_n <= 1'h1;
    recover();
    $display("test pushbutton done");
    for (int s = 0; s < 3; s++)
    begin
      @(posedge core_clk)
      begin
        timeout_select <= s[1:0];
        run <= 1'h0;
      end
      watch(50 * TC, 1'h0);
      @(posedge core_clk) kick <= 1'h1;
      watch(tmo[s] * TC - 50 * TC - 80, 1'h0);
      reach(1'h1, 200);
      @(posedge core_clk)
      begin
        run <= 1'h1;
        kick <= 1'h0;
      end
      recover();
    end
    $display("test watchdog done");
    give_verdict();
  end
endmodule
